// ===== vbr_defines.vh
// constants for the boot, frequency, address and input-sense register slice
// assumes inclusion by bare name from the register file and its bench
`ifndef VBR_DEFINES_VH
`define VBR_DEFINES_VH

// ---------------------------------------------------------------
// command codes (register offsets)
// ---------------------------------------------------------------
`define VBR_CMD_BOOT      8'hBB
`define VBR_CMD_SHUTDOWN  8'hBC
`define VBR_CMD_FREQ      8'hBD
`define VBR_CMD_BUS_ID    8'hBE
`define VBR_CMD_VIN_OFS   8'hBF
`define VBR_CMD_VIN_SCALE 8'hC0

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define VBR_CODE9_MSB     8
`define VBR_ADDR_MODE_BIT 7
`define VBR_ADDR_HI_MSB   6
`define VBR_ADDR_HI_LSB   4
`define VBR_ADDR_LO_MSB   3
`define VBR_LOSS_MSB      15
`define VBR_LOSS_LSB      8
`define VBR_VOFS_SIGN     7
`define VBR_RW_BIT        0

// ---------------------------------------------------------------
// reset values and scale factors
// ---------------------------------------------------------------
`define VBR_RST_BOOT      9'h000
`define VBR_RST_SHUTDOWN  9'h000
`define VBR_RST_FREQ      9'h000
`define VBR_RST_BUS_ID    8'h00
`define VBR_RST_VIN_OFS   16'h0000
`define VBR_RST_VIN_SCALE 8'h00
`define VBR_FREQ_STEP_KHZ 13'h000A

`endif

// ===== vbr_sync.v
// two-flop synchroniser for a bundle of independent levels
// assumes each bit is a slow level; no bus coherency is implied
`timescale 1ns/1ps

module vbr_sync #(
  parameter         W       = 1,
  parameter [W-1:0] RST_VAL = {W{1'b0}}
) (
  // clock and reset
  input  wire         clock,
  input  wire         rst_n,
  // levels
  input  wire [W-1:0] d,
  output reg  [W-1:0] q_ff
);

  reg [W-1:0] meta_ff;

  // first stage feeds only the second
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      meta_ff <= RST_VAL;
      q_ff    <= RST_VAL;
    end else begin
      meta_ff <= d;
      q_ff    <= meta_ff;
    end
  end

endmodule // vbr_sync

// ===== vbr_i2c_phy.v
// bit level of the serial command port: start/stop, byte shift, ack slot
// assumes scl_s and sda_s are already synchronised to clock
`timescale 1ns/1ps

module vbr_i2c_phy (
  // clock and reset
  input  wire       clock,
  input  wire       rst_n,
  // synchronised line levels
  input  wire       scl_s,
  input  wire       sda_s,
  // byte layer controls
  input  wire       ack_i,
  input  wire       tx_i,
  input  wire [7:0] tx_byte_i,
  // byte layer events
  output reg        start_ff,
  output reg        stop_ff,
  output reg        rx_stb_ff,
  output reg  [7:0] rx_byte_ff,
  output reg        tx_stb_ff,
  // data line drive, high pulls the line low
  output reg        sda_oe_ff
);

  reg       scl_d_ff;
  reg       sda_d_ff;
  reg       active_ff;
  reg       txing_ff;
  reg       mack_ff;
  reg [3:0] cnt_ff;
  reg [7:0] sh_ff;

  wire rise    = scl_s & ~scl_d_ff;
  wire fall    = ~scl_s & scl_d_ff;
  wire start_w = scl_s & scl_d_ff & sda_d_ff & ~sda_s;
  wire stop_w  = scl_s & scl_d_ff & ~sda_d_ff & sda_s;

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      scl_d_ff   <= 1'b1;
      sda_d_ff   <= 1'b1;
      active_ff  <= 1'b0;
      txing_ff   <= 1'b0;
      mack_ff    <= 1'b1;
      cnt_ff     <= 4'h0;
      sh_ff      <= 8'h00;
      start_ff   <= 1'b0;
      stop_ff    <= 1'b0;
      rx_stb_ff  <= 1'b0;
      rx_byte_ff <= 8'h00;
      tx_stb_ff  <= 1'b0;
      sda_oe_ff  <= 1'b0;
    end else begin
      scl_d_ff  <= scl_s;
      sda_d_ff  <= sda_s;
      start_ff  <= 1'b0;
      stop_ff   <= 1'b0;
      rx_stb_ff <= 1'b0;
      tx_stb_ff <= 1'b0;
      if (start_w) begin
        active_ff <= 1'b1;
        txing_ff  <= 1'b0;
        cnt_ff    <= 4'hF; // first scl fall wraps to zero
        sda_oe_ff <= 1'b0;
        start_ff  <= 1'b1;
      end else if (stop_w) begin
        active_ff <= 1'b0;
        txing_ff  <= 1'b0;
        sda_oe_ff <= 1'b0;
        stop_ff   <= 1'b1;
      end else if (active_ff & rise) begin
        if (cnt_ff == 4'h8) begin
          mack_ff <= sda_s;
        end else if (!txing_ff) begin
          sh_ff <= {sh_ff[6:0], sda_s};
          if (cnt_ff == 4'h7) begin
            rx_stb_ff  <= 1'b1;
            rx_byte_ff <= {sh_ff[6:0], sda_s};
          end
        end
      end else if (active_ff & fall) begin
        if (cnt_ff == 4'h8) begin
          cnt_ff <= 4'h0;
          if (tx_i && (!txing_ff || !mack_ff)) begin
            sh_ff     <= tx_byte_i;
            sda_oe_ff <= ~tx_byte_i[7];
            txing_ff  <= 1'b1;
            tx_stb_ff <= 1'b1;
          end else if (txing_ff) begin
            // master refused the byte: stay off the line until a new start
            active_ff <= 1'b0;
            txing_ff  <= 1'b0;
            sda_oe_ff <= 1'b0;
          end else begin
            sda_oe_ff <= 1'b0;
          end
        end else if (cnt_ff == 4'h7) begin
          cnt_ff    <= 4'h8;
          sda_oe_ff <= txing_ff ? 1'b0 : ack_i;
        end else begin
          cnt_ff <= cnt_ff + 4'h1;
          if (txing_ff) begin
            sh_ff     <= {sh_ff[6:0], 1'b0};
            sda_oe_ff <= ~sh_ff[6];
          end
        end
      end
    end
  end

endmodule // vbr_i2c_phy

// ===== vbr_boot_freq_addr_vin_regs.v
// boot, shutdown threshold, frequency, bus identity and input-sense registers
// behind the serial command port, plus the logic that uses them
// assumes the wire-and of scl/sda is resolved outside; controls on the
// regulator side share clock
//
// Summary of operation
// - reserved bits drop on write and read back as zero
// - nine-bit boot code is the start-up target in pulse-id mode
// - phases go tri-state once id reaches threshold during shutdown or ramp
// - nine-bit frequency code sets switching rate at 10 kHz per step
// - selector 0 takes low address from strap pins, 1 from register
// - address is three-bit upper field above four-bit lower field
// - loss trim weighted 0.5 W or 1 W by current step select
// - input offset is signed, top bit sign, magnitude given out
// - eight-bit divider ratio code scales input voltage sensing
`timescale 1ns/1ps
`include "vbr_defines.vh"

module vbr_boot_freq_addr_vin_regs (
  // clock and reset
  input  wire       clock,
  input  wire       rst_b,
  // serial command port
  input  wire       scl_i,
  input  wire       sda_i,
  output reg        sda_o_ff,
  output wire       sda_oe_ff,
  // address strap pins
  input  wire [3:0] addr_strap_i,
  // regulator controls
  input  wire       pulse_voltage_id_interface_i,
  input  wire [8:0] other_start_code_i,
  input  wire       soft_shutdown_i,
  input  wire       dynamic_voltage_ramp_i,
  input  wire [8:0] vid_now_i,
  input  wire       sum_current_step_select_i,
  // results for the regulator
  output reg  [8:0] start_target_code_ff,
  output reg        phase_tristate_ff,
  output reg  [8:0] switch_freq_code_ff,
  output reg [12:0] switch_freq_khz_ff,
  output reg  [6:0] bus_address_ff,
  output reg  [8:0] loss_trim_half_watt_ff,
  output reg        vin_offset_neg_ff,
  output reg  [7:0] vin_offset_mag_ff,
  output reg  [7:0] vin_sense_scale_ff
);

  // ---------------------------------------------------------------
  // reset release and pin synchronisers
  // ---------------------------------------------------------------
  wire       rst_n;
  wire [1:0] line_s;
  wire [3:0] strap_s;

  vbr_sync #(.W(1), .RST_VAL(1'b0)) u_rst_sync (
    .clock (clock),
    .rst_n (rst_b),
    .d     (1'b1),
    .q_ff  (rst_n)
  );

  // lines idle high, so they reset high to avoid a false start
  vbr_sync #(.W(2), .RST_VAL(2'b11)) u_line_sync (
    .clock (clock),
    .rst_n (rst_n),
    .d     ({scl_i, sda_i}),
    .q_ff  (line_s)
  );

  vbr_sync #(.W(4), .RST_VAL(4'h0)) u_strap_sync (
    .clock (clock),
    .rst_n (rst_n),
    .d     (addr_strap_i),
    .q_ff  (strap_s)
  );

  // ---------------------------------------------------------------
  // bit engine
  // ---------------------------------------------------------------
  wire       start_w;
  wire       stop_w;
  wire       rx_stb_w;
  wire [7:0] rx_byte_w;
  wire       tx_stb_w;
  reg        ack_ff;
  reg        tx_ff;
  reg  [7:0] tx_byte;

  vbr_i2c_phy u_phy (
    .clock      (clock),
    .rst_n      (rst_n),
    .scl_s      (line_s[1]),
    .sda_s      (line_s[0]),
    .ack_i      (ack_ff),
    .tx_i       (tx_ff),
    .tx_byte_i  (tx_byte),
    .start_ff   (start_w),
    .stop_ff    (stop_w),
    .rx_stb_ff  (rx_stb_w),
    .rx_byte_ff (rx_byte_w),
    .tx_stb_ff  (tx_stb_w),
    .sda_oe_ff  (sda_oe_ff)
  );

  // ---------------------------------------------------------------
  // command decode helpers
  // ---------------------------------------------------------------
  function cmd_known;
    input [7:0] c;
    begin
      cmd_known = (c == `VBR_CMD_BOOT) || (c == `VBR_CMD_SHUTDOWN) ||
                  (c == `VBR_CMD_FREQ) || (c == `VBR_CMD_BUS_ID) ||
                  (c == `VBR_CMD_VIN_OFS) || (c == `VBR_CMD_VIN_SCALE);
    end
  endfunction

  function cmd_wide;
    input [7:0] c;
    begin
      cmd_wide = (c != `VBR_CMD_BUS_ID) && (c != `VBR_CMD_VIN_SCALE);
    end
  endfunction

  // ---------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------
  reg  [8:0] boot_code_ff;
  reg  [8:0] tristate_code_ff;
  reg  [8:0] freq_code_ff;
  reg  [7:0] bus_id_ff;
  reg [15:0] vin_ofs_ff;
  reg  [7:0] vin_scale_ff;
  reg  [7:0] cmd_ff;
  reg        wr_stb_ff;
  reg [15:0] wr_data_ff;
  reg [15:0] rd_word;

  always @* begin
    case (cmd_ff)
      `VBR_CMD_BOOT:      rd_word = {7'h00, boot_code_ff};
      `VBR_CMD_SHUTDOWN:  rd_word = {7'h00, tristate_code_ff};
      `VBR_CMD_FREQ:      rd_word = {7'h00, freq_code_ff};
      `VBR_CMD_BUS_ID:    rd_word = {8'h00, bus_id_ff};
      `VBR_CMD_VIN_OFS:   rd_word = vin_ofs_ff;
      `VBR_CMD_VIN_SCALE: rd_word = {8'h00, vin_scale_ff};
      default:            rd_word = 16'h0000;
    endcase
  end

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      boot_code_ff     <= `VBR_RST_BOOT;
      tristate_code_ff <= `VBR_RST_SHUTDOWN;
      freq_code_ff     <= `VBR_RST_FREQ;
      bus_id_ff        <= `VBR_RST_BUS_ID;
      vin_ofs_ff       <= `VBR_RST_VIN_OFS;
      vin_scale_ff     <= `VBR_RST_VIN_SCALE;
    end else if (wr_stb_ff) begin
      case (cmd_ff)
        `VBR_CMD_BOOT:      boot_code_ff     <= wr_data_ff[`VBR_CODE9_MSB:0];
        `VBR_CMD_SHUTDOWN:  tristate_code_ff <= wr_data_ff[`VBR_CODE9_MSB:0];
        `VBR_CMD_FREQ:      freq_code_ff     <= wr_data_ff[`VBR_CODE9_MSB:0];
        `VBR_CMD_BUS_ID:    bus_id_ff        <= wr_data_ff[7:0];
        `VBR_CMD_VIN_OFS:   vin_ofs_ff       <= wr_data_ff;
        `VBR_CMD_VIN_SCALE: vin_scale_ff     <= wr_data_ff[7:0];
        default:            vin_scale_ff     <= vin_scale_ff;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // transaction layer
  // ---------------------------------------------------------------
  localparam [4:0] ST_IDLE = 5'b00001;
  localparam [4:0] ST_ADDR = 5'b00010;
  localparam [4:0] ST_CMD  = 5'b00100;
  localparam [4:0] ST_WR   = 5'b01000;
  localparam [4:0] ST_RD   = 5'b10000;

  reg  [4:0] state_ff;
  reg  [1:0] idx_ff;
  reg  [7:0] lo_ff;
  wire [6:0] own_addr;

  // low byte first, high byte next, then zeros
  always @* begin
    case (idx_ff)
      2'd0:    tx_byte = rd_word[7:0];
      2'd1:    tx_byte = cmd_wide(cmd_ff) ? rd_word[15:8] : 8'h00;
      default: tx_byte = 8'h00;
    endcase
  end

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_ff   <= ST_IDLE;
      idx_ff     <= 2'd0;
      lo_ff      <= 8'h00;
      cmd_ff     <= 8'h00;
      ack_ff     <= 1'b0;
      tx_ff      <= 1'b0;
      wr_stb_ff  <= 1'b0;
      wr_data_ff <= 16'h0000;
    end else begin
      wr_stb_ff <= 1'b0;
      if (start_w) begin
        state_ff <= ST_ADDR;
        ack_ff   <= 1'b0;
        tx_ff    <= 1'b0;
      end else if (stop_w) begin
        state_ff <= ST_IDLE;
        ack_ff   <= 1'b0;
        tx_ff    <= 1'b0;
      end else if (tx_stb_w && state_ff == ST_RD) begin
        if (idx_ff != 2'd2)
          idx_ff <= idx_ff + 2'd1;
      end else if (rx_stb_w) begin
        case (state_ff)
          ST_ADDR: begin
            idx_ff <= 2'd0;
            if (rx_byte_w[7:1] != own_addr) begin
              ack_ff   <= 1'b0;
              state_ff <= ST_IDLE;
            end else if (rx_byte_w[`VBR_RW_BIT]) begin
              ack_ff   <= 1'b1;
              tx_ff    <= 1'b1;
              state_ff <= ST_RD;
            end else begin
              ack_ff   <= 1'b1;
              state_ff <= ST_CMD;
            end
          end
          ST_CMD: begin
            cmd_ff   <= rx_byte_w;
            ack_ff   <= cmd_known(rx_byte_w);
            state_ff <= cmd_known(rx_byte_w) ? ST_WR : ST_IDLE;
          end
          // commit after the last byte of the register width
          ST_WR: begin
            if (idx_ff == 2'd0 && cmd_wide(cmd_ff)) begin
              lo_ff  <= rx_byte_w;
              idx_ff <= 2'd1;
              ack_ff <= 1'b1;
            end else if (idx_ff == 2'd0) begin
              wr_data_ff <= {8'h00, rx_byte_w};
              wr_stb_ff  <= 1'b1;
              idx_ff     <= 2'd2;
              ack_ff     <= 1'b1;
            end else if (idx_ff == 2'd1) begin
              wr_data_ff <= {rx_byte_w, lo_ff};
              wr_stb_ff  <= 1'b1;
              idx_ff     <= 2'd2;
              ack_ff     <= 1'b1;
            end else begin
              ack_ff <= 1'b0;
            end
          end
          default: ack_ff <= 1'b0;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // users of the stored settings
  // ---------------------------------------------------------------
  // strap or register for low part
  assign own_addr = {bus_id_ff[`VBR_ADDR_HI_MSB:`VBR_ADDR_HI_LSB],
                     bus_id_ff[`VBR_ADDR_MODE_BIT] ? bus_id_ff[`VBR_ADDR_LO_MSB:0] : strap_s};

  wire [7:0] ofs_code = vin_ofs_ff[7:0];
  wire [7:0] loss     = vin_ofs_ff[`VBR_LOSS_MSB:`VBR_LOSS_LSB];
  wire       ramp_dn  = soft_shutdown_i | dynamic_voltage_ramp_i;

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sda_o_ff               <= 1'b0;
      start_target_code_ff   <= 9'h000;
      phase_tristate_ff      <= 1'b0;
      switch_freq_code_ff    <= 9'h000;
      switch_freq_khz_ff     <= 13'h0000;
      bus_address_ff         <= 7'h00;
      loss_trim_half_watt_ff <= 9'h000;
      vin_offset_neg_ff      <= 1'b0;
      vin_offset_mag_ff      <= 8'h00;
      vin_sense_scale_ff     <= 8'h00;
    end else begin
      sda_o_ff <= 1'b0;
      start_target_code_ff <= pulse_voltage_id_interface_i ? boot_code_ff
                                                           : other_start_code_i;
      // tri-state held until the ramp ends
      if (!ramp_dn)
        phase_tristate_ff <= 1'b0;
      else if (vid_now_i <= tristate_code_ff)
        phase_tristate_ff <= 1'b1;
      switch_freq_code_ff <= freq_code_ff;
      switch_freq_khz_ff  <= {4'h0, freq_code_ff} * `VBR_FREQ_STEP_KHZ;
      bus_address_ff      <= own_addr;
      // half-watt units, doubled at 1 W step
      loss_trim_half_watt_ff <= sum_current_step_select_i ? {loss, 1'b0}
                                                          : {1'b0, loss};
      vin_offset_neg_ff <= ofs_code[`VBR_VOFS_SIGN];
      vin_offset_mag_ff <= ofs_code[`VBR_VOFS_SIGN] ? (~ofs_code + 8'h01) : ofs_code;
      vin_sense_scale_ff <= vin_scale_ff;
    end
  end

endmodule // vbr_boot_freq_addr_vin_regs

// ===== vbr_regs_asserts.sv
// checker for the register slice, watching the top module's ports only
// assumes one clock and the asynchronous active-low reset rst_b
`timescale 1ns/1ps

module vbr_regs_asserts (
  // clock and reset
  input logic        clock,
  input logic        rst_b,
  // serial command port
  input logic        scl_i,
  input logic        sda_i,
  input logic        sda_o_ff,
  input logic        sda_oe_ff,
  // address strap and regulator controls
  input logic [3:0]  addr_strap_i,
  input logic        pulse_voltage_id_interface_i,
  input logic [8:0]  other_start_code_i,
  input logic        soft_shutdown_i,
  input logic        dynamic_voltage_ramp_i,
  input logic [8:0]  vid_now_i,
  input logic        sum_current_step_select_i,
  // results
  input logic [8:0]  start_target_code_ff,
  input logic        phase_tristate_ff,
  input logic [8:0]  switch_freq_code_ff,
  input logic [12:0] switch_freq_khz_ff,
  input logic [6:0]  bus_address_ff,
  input logic [8:0]  loss_trim_half_watt_ff,
  input logic        vin_offset_neg_ff,
  input logic [7:0]  vin_offset_mag_ff,
  input logic [7:0]  vin_sense_scale_ff
);
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  reg  [2:0] up_cnt_ff;
  wire       up   = (up_cnt_ff == 3'h5);
  wire       shut = soft_shutdown_i | dynamic_voltage_ramp_i;

  // internal reset lingers a few edges after release, so wait it out
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) up_cnt_ff <= 3'h0;
    else if (!up) up_cnt_ff <= up_cnt_ff + 3'h1;
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  sequence scl_rise; $rose(scl_i); endsequence
  sequence oe_still; $stable(sda_oe_ff) [*6]; endsequence
  sequence wind_down; up && shut && phase_tristate_ff; endsequence

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  freq_scale_a: assert property (up |->
    switch_freq_khz_ff == switch_freq_code_ff * 13'h000A)
    else $error("kHz is not ten times the code");
  start_mux_a: assert property (up && !pulse_voltage_id_interface_i |=>
    start_target_code_ff == $past(other_start_code_i)) else $error("start target mux wrong");
  tri_clear_a: assert property (up && !shut |=> !phase_tristate_ff)
    else $error("phases stay tri-state after wind-down ended");
  tri_hold_a: assert property (wind_down |=> phase_tristate_ff)
    else $error("tri-state dropped during wind-down");
  tri_cause_a: assert property (up && $rose(phase_tristate_ff) |-> $past(shut))
    else $error("tri-state without wind-down");
  tri_zero_a: assert property (up && shut && vid_now_i == 9'h000 |=> phase_tristate_ff)
    else $error("tri-state missing at id zero");
  loss_step_a: assert property (up |-> ($past(sum_current_step_select_i) ?
    !loss_trim_half_watt_ff[0] : !loss_trim_half_watt_ff[8])) else $error("loss weight wrong");
  ofs_pos_a: assert property (up && !vin_offset_neg_ff |-> !vin_offset_mag_ff[7])
    else $error("positive offset magnitude too large");
  ofs_neg_a: assert property (up && vin_offset_neg_ff |-> vin_offset_mag_ff != 8'h00 &&
    vin_offset_mag_ff <= 8'h80) else $error("negative offset magnitude out of range");
  ack_edge_a: assert property (up && $changed(sda_oe_ff) |-> !scl_i)
    else $error("data drive changed while clock line high");
  bit_stand_a: assert property (up ##0 scl_rise |=> oe_still)
    else $error("data drive moved during clock high");
endmodule // vbr_regs_asserts

// ===== vbr_host_model.sv
// host model of the serial command port: start, stop, byte moves
// assumes the bench resolves the open-drain data line with a pull-up
`timescale 1ns/1ps

module vbr_host_model (
  // clock
  input  wire clock,
  // bus lines
  input  wire sda_line,
  output reg  scl_o,
  output reg  sda_pull
);
  initial begin
    scl_o = 1'b1;
    sda_pull = 1'b0;
  end
  // quarter bit of eight clocks; the device needs scl low six clocks
  task quarter;
    repeat (8) @(negedge clock);
  endtask
  task bit_io(input b, output r);
    begin
      sda_pull = ~b;
      quarter;
      scl_o = 1'b1;
      quarter;
      r = sda_line;
      quarter;
      scl_o = 1'b0;
      quarter;
    end
  endtask
  task start;
    begin
      sda_pull = 1'b0;
      quarter;
      scl_o = 1'b1;
      quarter;
      sda_pull = 1'b1;
      quarter;
      scl_o = 1'b0;
      quarter;
    end
  endtask
  task stop;
    begin
      sda_pull = 1'b1;
      quarter;
      scl_o = 1'b1;
      quarter;
      sda_pull = 1'b0;
      quarter;
    end
  endtask
  task byte_io(input [7:0] d, input last, output [7:0] r, output a);
    integer i;
    begin
      for (i = 7; i >= 0; i = i - 1) bit_io(d[i], r[i]);
      bit_io(last, a);
    end
  endtask
  task write_reg(input [6:0] dev, input [7:0] cmd, input [15:0] v, input wide, output nak);
    reg [7:0] r;
    reg       a0, a1, a2, a3;
    begin
      a3 = 1'b0;
      start;
      byte_io({dev, 1'b0}, 1'b1, r, a0);
      byte_io(cmd, 1'b1, r, a1);
      byte_io(v[7:0], 1'b1, r, a2);
      if (wide) byte_io(v[15:8], 1'b1, r, a3);
      stop;
      nak = a0 | a1 | a2 | a3;
    end
  endtask
  task read_reg(input [6:0] dev, input [7:0] cmd, input wide, output [15:0] v, output nak);
    reg [7:0] r;
    reg       a0, a1, a2, a3;
    begin
      v = 16'h0000;
      start;
      byte_io({dev, 1'b0}, 1'b1, r, a0);
      byte_io(cmd, 1'b1, r, a1);
      start;
      byte_io({dev, 1'b1}, 1'b1, r, a2);
      byte_io(8'hFF, ~wide, v[7:0], a3);
      if (wide) byte_io(8'hFF, 1'b1, v[15:8], a3);
      stop;
      nak = a0 | a1 | a2;
    end
  endtask
endmodule // vbr_host_model

// ===== vbr_boot_freq_addr_vin_regs_tb.sv
// self-checking bench for the register slice and its outputs
// assumes the host model and checker files are compiled before it
`timescale 1ns/1ps
`include "vbr_defines.vh"

module vbr_boot_freq_addr_vin_regs_tb;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  localparam [47:0] CMDS  = {`VBR_CMD_BUS_ID, `VBR_CMD_VIN_SCALE, `VBR_CMD_VIN_OFS,
                             `VBR_CMD_FREQ, `VBR_CMD_SHUTDOWN, `VBR_CMD_BOOT};
  localparam [79:0] MASKS = {16'h00FF, 16'hFFFF, 16'h01FF, 16'h01FF, 16'h01FF};
  reg         clock, rst_b, pvid, sd, ramp, ssel, nak;
  reg  [3:0]  strap;
  reg  [8:0]  other, vid;
  reg  [6:0]  dev;
  reg  [15:0] rnd, v, w, val [0:4];
  reg  [15:0] exp_q [$], got_q [$];
  wire        scl, pull, oe, sda_o, neg, tri_st;
  wire        sda = ~(pull | oe);
  wire [8:0]  start_t, fcode, loss;
  wire [12:0] khz;
  wire [6:0]  baddr;
  wire [7:0]  mag, scale;
  integer     mismatches, n_tests, i;

  vbr_boot_freq_addr_vin_regs u_dut (.clock(clock), .rst_b(rst_b), .scl_i(scl), .sda_i(sda),
    .sda_o_ff(sda_o), .sda_oe_ff(oe), .addr_strap_i(strap),
    .pulse_voltage_id_interface_i(pvid), .other_start_code_i(other), .soft_shutdown_i(sd),
    .dynamic_voltage_ramp_i(ramp), .vid_now_i(vid), .sum_current_step_select_i(ssel),
    .start_target_code_ff(start_t), .phase_tristate_ff(tri_st), .switch_freq_code_ff(fcode),
    .switch_freq_khz_ff(khz), .bus_address_ff(baddr), .loss_trim_half_watt_ff(loss),
    .vin_offset_neg_ff(neg), .vin_offset_mag_ff(mag), .vin_sense_scale_ff(scale));
  vbr_host_model u_host (.clock(clock), .sda_line(sda), .scl_o(scl), .sda_pull(pull));

  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  function [15:0] lfsr(input [15:0] s);
    lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task note(input [15:0] e, input [15:0] g);
    begin
      exp_q.push_back(e);
      got_q.push_back(g);
    end
  endtask
  task cmp(input [15:0] e, input [15:0] g);
    begin
      n_tests = n_tests + 1;
      if (g !== e) begin
        mismatches = mismatches + 1;
        $display("[ERR] %0t got %h expected %h", $time, g, e);
      end
    end
  endtask
  task settle;
    repeat (3) @(negedge clock);
  endtask
  task tri_step(input s, input r, input [8:0] n, input e);
    begin
      sd = s;
      ramp = r;
      vid = n;
      settle;
      note({15'h0000, e}, {15'h0000, tri_st});
    end
  endtask
  task end_of_test;
    begin
      $display("counts: %0d compares, %0d mismatches", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0)
        $display("DONE - PASS");
      else
        $display("DONE - FAIL");
      $finish;
    end
  endtask

  always @(posedge clock) if (got_q.size() > 0) cmp(exp_q.pop_front(), got_q.pop_front());

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  initial begin
    repeat (80000) @(posedge clock);
    $display("[ERR] %0t run did not finish", $time);
    mismatches = mismatches + 1;
    end_of_test;
  end

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  initial begin
    {rst_b, pvid, sd, ramp, ssel} = 5'h00;
    strap = 4'h5;
    other = 9'h123;
    vid = 9'h1FF;
    dev = 7'h05;
    rnd = 16'h9B16;
    mismatches = 0;
    n_tests = 0;
    repeat (2) @(negedge clock);
    rst_b = 1'b1;
    repeat (12) @(negedge clock);
    for (i = 0; i < 6; i = i + 1) begin
      u_host.read_reg(dev, CMDS[8*i +: 8], i < 4, v, nak);
      note(16'h0000, v);
    end
    note(16'h0005, {9'h000, baddr});
    note(16'h0000, {15'h0000, sda_o});
    $display("test reset_values done");
    for (i = 0; i < 5; i = i + 1) begin
      rnd = lfsr(rnd);
      w = (i < 4) ? rnd : {8'h00, rnd[7:0]};
      if (i == 3) w[7] = 1'b1;
      u_host.write_reg(dev, CMDS[8*i +: 8], w, i < 4, nak);
      note(16'h0000, {15'h0000, nak});
      val[i] = w & MASKS[16*i +: 16];
      u_host.read_reg(dev, CMDS[8*i +: 8], i < 4, v, nak);
      note(val[i], v);
    end
    $display("test write_readback done");
    pvid = 1'b1;
    settle;
    note(val[0], {7'h00, start_t});
    pvid = 1'b0;
    other = rnd[8:0];
    settle;
    note({7'h00, other}, {7'h00, start_t});
    note(val[2], {7'h00, fcode});
    note(val[2] * 16'h000A, {3'h0, khz});
    note({8'h00, val[3][15:8]}, {7'h00, loss});
    ssel = 1'b1;
    settle;
    note({7'h00, val[3][15:8], 1'b0}, {7'h00, loss});
    w[7:0] = val[3][7] ? 8'h00 - val[3][7:0] : val[3][7:0];
    note({7'h00, val[3][7], w[7:0]}, {7'h00, neg, mag});
    note({8'h00, val[4][7:0]}, {8'h00, scale});
    $display("test derived_outputs done");
    u_host.write_reg(dev, `VBR_CMD_SHUTDOWN, 16'hFE80, 1'b1, nak);
    tri_step(1'b1, 1'b0, 9'h081, 1'b0);
    tri_step(1'b1, 1'b0, 9'h080, 1'b1);
    tri_step(1'b1, 1'b0, 9'h0A0, 1'b1);
    tri_step(1'b0, 1'b0, 9'h0A0, 1'b0);
    tri_step(1'b0, 1'b1, 9'h07F, 1'b1);
    tri_step(1'b0, 1'b0, 9'h1FF, 1'b0);
    tri_step(1'b1, 1'b0, 9'h000, 1'b1);
    tri_step(1'b0, 1'b0, 9'h1FF, 1'b0);
    $display("test tristate done");
    u_host.write_reg(dev, `VBR_CMD_BUS_ID, 16'h00B3, 1'b0, nak);
    settle;
    note(16'h0033, {9'h000, baddr});
    dev = 7'h33;
    u_host.read_reg(dev, `VBR_CMD_BUS_ID, 1'b0, v, nak);
    note(16'h00B3, v);
    u_host.write_reg(dev, `VBR_CMD_BUS_ID, 16'h002F, 1'b0, nak);
    strap = 4'h9;
    repeat (8) @(negedge clock);
    note(16'h0029, {9'h000, baddr});
    dev = 7'h29;
    $display("test bus_address done");
    // stale address and unknown command are both refused
    u_host.write_reg(7'h33, `VBR_CMD_FREQ, 16'h0155, 1'b1, nak);
    note(16'h0001, {15'h0000, nak});
    u_host.write_reg(dev, 8'hC1, 16'h0011, 1'b1, nak);
    note(16'h0001, {15'h0000, nak});
    u_host.write_reg(dev, `VBR_CMD_FREQ, 16'h0077, 1'b0, nak);
    u_host.read_reg(dev, `VBR_CMD_FREQ, 1'b1, v, nak);
    note(val[2], v);
    $display("test refusals done");
    repeat (3) @(posedge clock);
    end_of_test;
  end
endmodule // vbr_boot_freq_addr_vin_regs_tb

bind vbr_boot_freq_addr_vin_regs vbr_regs_asserts u_chk (.clock(clock), .rst_b(rst_b),
  .scl_i(scl_i), .sda_i(sda_i), .sda_o_ff(sda_o_ff), .sda_oe_ff(sda_oe_ff),
  .addr_strap_i(addr_strap_i), .pulse_voltage_id_interface_i(pulse_voltage_id_interface_i),
  .other_start_code_i(other_start_code_i), .soft_shutdown_i(soft_shutdown_i),
  .dynamic_voltage_ramp_i(dynamic_voltage_ramp_i), .vid_now_i(vid_now_i),
  .sum_current_step_select_i(sum_current_step_select_i),
  .start_target_code_ff(start_target_code_ff), .phase_tristate_ff(phase_tristate_ff),
  .switch_freq_code_ff(switch_freq_code_ff), .switch_freq_khz_ff(switch_freq_khz_ff),
  .bus_address_ff(bus_address_ff), .loss_trim_half_watt_ff(loss_trim_half_watt_ff),
  .vin_offset_neg_ff(vin_offset_neg_ff), .vin_offset_mag_ff(vin_offset_mag_ff),
  .vin_sense_scale_ff(vin_sense_scale_ff));
